/* File: src/srp_register_programming.sv */
// Telegram command interpreter of the sensor settings registers
`include "srp_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module srp_register_programming #(
	parameter int unsigned P_PROG_CYCLES = `SRP_PROG_TIME_MS * `SRP_CLK_KHZ
) (
	input wire logic i_clock,
	input wire logic i_rst_n,
	input wire logic i_tel_valid,
	input wire logic [2:0] i_tel_cmd,
	input wire logic i_tel_cmd_par,
	input wire logic [3:0] i_tel_adr,
	input wire logic i_tel_adr_par,
	input wire logic [15:0] i_tel_data,
	input wire logic i_tel_data_par,
	input wire logic [13:0] i_dac_value,
	input wire logic i_activate_pin,
	output logic o_ack,
	output logic o_rd_valid,
	output logic [15:0] o_rd_data,
	output logic o_rd_par,
	output logic o_sensor_active,
	output logic o_protect_active
);
	srp_pkg::srp_state_t state_reg, state_next;
	logic [2:0] cmd_reg, cmd_next;
	logic [3:0] adr_reg, adr_next;
	logic [31:0] busy_cnt_reg, busy_cnt_next;
	logic [1:0] gp_ptr_reg, gp_ptr_next;
	logic erased_reg, erased_next;
	logic protect_reg, protect_next;
	// Blank cell at power-on; reset must not touch it
	logic lock_nv_reg = 1'b0;
	logic lock_nv_next;
	logic rd_valid_reg, rd_valid_next;
	logic [15:0] rd_data_reg, rd_data_next;
	logic rd_par_reg, rd_par_next;
	logic act_s1_reg, act_s2_reg, act_s3_reg;

	logic par_ok, take, mapped, readable, writable, act_edge;
	logic [3:0] width, idx, shift;
	logic [13:0] mask, aligned, dac_rev;
	logic mem_wr_en, mem_erase, mem_program, mem_reload;
	srp_pkg::srp_word_t mem_rd;

	// Width, access and store slot of each address
	always_comb begin
		width = 4'h0;
		readable = 1'b1;
		writable = 1'b1;
		idx = i_tel_adr;
		unique case (i_tel_adr)
			`SRP_ADR_CLAMP_LOW: width = `SRP_W_CLAMP_LOW;
			`SRP_ADR_CLAMP_HIGH: width = `SRP_W_CLAMP_HIGH;
			`SRP_ADR_QUIESCENT: width = `SRP_W_QUIESCENT;
			`SRP_ADR_GAIN: width = `SRP_W_GAIN;
			`SRP_ADR_CONFIG: width = `SRP_W_CONFIG;
			`SRP_ADR_PROTECT: width = `SRP_W_PROTECT;
			`SRP_ADR_TEMPCO: width = `SRP_W_TEMPCO;
			`SRP_ADR_SPARE0: width = `SRP_W_SPARE;
			`SRP_ADR_SPARE13: begin
				width = `SRP_W_SPARE;
				unique case (gp_ptr_reg)
					2'h0: idx = `SRP_SLOT_SPARE13_0;
					2'h1: idx = `SRP_SLOT_SPARE13_1;
					default: idx = `SRP_SLOT_SPARE13_2;
				endcase
			end
			`SRP_ADR_DAC: begin
				width = `SRP_W_DAC;
				writable = 1'b0;
			end
			`SRP_ADR_SHUTDOWN: begin
				width = `SRP_W_SHUTDOWN;
				readable = 1'b0;
			end
			default: begin
				readable = 1'b0;
				writable = 1'b0;
			end
		endcase
		mask = 14'((15'h1 << width) - 15'h1);
	end

	// Parity as the programmer builds it; any mismatch drops the telegram
	assign par_ok = (i_tel_cmd_par == ~^i_tel_cmd) && (i_tel_adr_par == ^i_tel_adr)
		&& (i_tel_data_par == ~^i_tel_data);
	always_comb begin
		mapped = 1'b0;
		unique case (i_tel_cmd)
			`SRP_CMD_READ: mapped = readable;
			`SRP_CMD_WRITE: mapped = writable;
			`SRP_CMD_PROGRAM, `SRP_CMD_ERASE: mapped = 1'b1;
			default: mapped = 1'b0;
		endcase
	end
	assign take = i_tel_valid && (state_reg == srp_pkg::SRP_ST_IDLE) && par_ok && mapped;
	assign act_edge = act_s2_reg && !act_s3_reg;
	// DAC readback goes out least significant bit first
	assign dac_rev = {<<{i_dac_value}};

	// Only the value bits ending at bit 00 are kept
	assign mem_wr_en = take && (i_tel_cmd == `SRP_CMD_WRITE) && !protect_reg
		&& (i_tel_adr != `SRP_ADR_PROTECT) && (i_tel_adr != `SRP_ADR_SHUTDOWN);
	assign mem_reload = (state_reg == srp_pkg::SRP_ST_LOAD);
	assign mem_erase = (state_reg == srp_pkg::SRP_ST_BUSY) && (busy_cnt_reg == P_PROG_CYCLES - 1)
		&& (cmd_reg == `SRP_CMD_ERASE) && !protect_reg;
	// Program without a preceding erase is not applied
	assign mem_program = (state_reg == srp_pkg::SRP_ST_BUSY) && (busy_cnt_reg == P_PROG_CYCLES - 1)
		&& (cmd_reg == `SRP_CMD_PROGRAM) && !protect_reg && erased_reg;

	srp_word_store u_store (
		.i_clock(i_clock),
		.i_rst_n(i_rst_n),
		.i_wr_en(mem_wr_en),
		.i_wr_idx(idx),
		.i_wr_data(i_tel_data[13:0] & mask),
		.i_rd_idx(idx),
		.i_erase(mem_erase),
		.i_program(mem_program),
		.i_reload(mem_reload),
		.o_rd_data(mem_rd)
	);

	// Left alignment of the read value at bit 13
	always_comb begin
		shift = 4'(`SRP_W_FIELD - width_of_reg(adr_reg));
		aligned = 14'(mem_rd << shift);
	end

	function automatic logic [3:0] width_of_reg(input logic [3:0] a);
		logic [3:0] w;
		w = `SRP_W_SPARE;
		unique case (a)
			`SRP_ADR_CLAMP_LOW: w = `SRP_W_CLAMP_LOW;
			`SRP_ADR_CLAMP_HIGH: w = `SRP_W_CLAMP_HIGH;
			`SRP_ADR_QUIESCENT: w = `SRP_W_QUIESCENT;
			`SRP_ADR_GAIN: w = `SRP_W_GAIN;
			`SRP_ADR_CONFIG: w = `SRP_W_CONFIG;
			`SRP_ADR_TEMPCO: w = `SRP_W_TEMPCO;
			default: w = `SRP_W_SPARE;
		endcase
		return w;
	endfunction

	always_comb begin
		state_next = state_reg;
		cmd_next = cmd_reg;
		adr_next = adr_reg;
		busy_cnt_next = busy_cnt_reg;
		gp_ptr_next = gp_ptr_reg;
		erased_next = erased_reg;
		protect_next = protect_reg;
		lock_nv_next = lock_nv_reg;
		rd_valid_next = 1'b0;
		rd_data_next = rd_data_reg;
		rd_par_next = rd_par_reg;
		unique case (state_reg)
			srp_pkg::SRP_ST_LOAD: begin
				// Stored protection bit is copied into protect_reg only here
				protect_next = lock_nv_reg;
				state_next = srp_pkg::SRP_ST_IDLE;
			end
			srp_pkg::SRP_ST_IDLE: begin
				if (take) begin
					cmd_next = i_tel_cmd;
					adr_next = i_tel_adr;
					busy_cnt_next = '0;
					if (i_tel_adr == `SRP_ADR_SPARE0) begin
						gp_ptr_next = 2'h0;
					end else if (i_tel_adr == `SRP_ADR_SPARE13) begin
						gp_ptr_next = (gp_ptr_reg == `SRP_SPARE13_LAST) ? 2'h0 : 2'(gp_ptr_reg + 2'h1);
					end
					unique case (i_tel_cmd)
						`SRP_CMD_READ: state_next = srp_pkg::SRP_ST_READ;
						`SRP_CMD_WRITE: begin
							state_next = srp_pkg::SRP_ST_ACK;
							if (i_tel_adr == `SRP_ADR_PROTECT && !protect_reg) begin
								lock_nv_next = i_tel_data[0];
							end
							if (i_tel_adr == `SRP_ADR_SHUTDOWN && i_tel_data[11:0] == `SRP_SHUTDOWN_KEY) begin
								state_next = srp_pkg::SRP_ST_OFF;
							end
						end
						default: state_next = srp_pkg::SRP_ST_BUSY;
					endcase
				end
			end
			srp_pkg::SRP_ST_READ: begin
				rd_valid_next = 1'b1;
				if (adr_reg == `SRP_ADR_DAC) begin
					rd_data_next = {2'h0, dac_rev};
				end else if (adr_reg == `SRP_ADR_PROTECT) begin
					rd_data_next = {2'h0, lock_nv_reg, 13'h0000};
				end else begin
					rd_data_next = {2'h0, aligned};
				end
				rd_par_next = ~^rd_data_next;
				state_next = srp_pkg::SRP_ST_ACK;
			end
			srp_pkg::SRP_ST_BUSY: begin
				// Store time elapses before the copies change
				busy_cnt_next = busy_cnt_reg + 32'h1;
				if (busy_cnt_reg == P_PROG_CYCLES - 1) begin
					if (mem_erase) begin
						erased_next = 1'b1;
					end else if (mem_program) begin
						erased_next = 1'b0;
					end
					state_next = srp_pkg::SRP_ST_ACK;
				end
			end
			srp_pkg::SRP_ST_ACK: begin
				rd_valid_next = rd_valid_reg;
				state_next = srp_pkg::SRP_ST_IDLE;
			end
			srp_pkg::SRP_ST_OFF: begin
				// Telegrams are deaf here; a reset counts as a power cycle
				if (act_edge) begin
					state_next = srp_pkg::SRP_ST_IDLE;
				end
			end
		endcase
	end

	always_ff @(posedge i_clock) begin
		if (!i_rst_n) begin
			state_reg <= srp_pkg::SRP_ST_LOAD;
			cmd_reg <= 3'h0;
			adr_reg <= 4'h0;
			busy_cnt_reg <= 32'h0;
			gp_ptr_reg <= 2'h0;
			erased_reg <= 1'b0;
			protect_reg <= 1'b0;
			rd_valid_reg <= 1'b0;
			rd_data_reg <= 16'h0000;
			rd_par_reg <= 1'b0;
			act_s1_reg <= 1'b0;
			act_s2_reg <= 1'b0;
			act_s3_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			cmd_reg <= cmd_next;
			adr_reg <= adr_next;
			busy_cnt_reg <= busy_cnt_next;
			gp_ptr_reg <= gp_ptr_next;
			erased_reg <= erased_next;
			protect_reg <= protect_next;
			rd_valid_reg <= rd_valid_next;
			rd_data_reg <= rd_data_next;
			rd_par_reg <= rd_par_next;
			act_s1_reg <= i_activate_pin;
			act_s2_reg <= act_s1_reg;
			act_s3_reg <= act_s2_reg;
		end
	end

	// Stored bit, so it lives through reset
	always_ff @(posedge i_clock) begin
		lock_nv_reg <= lock_nv_next;
	end

	assign o_ack = (state_reg == srp_pkg::SRP_ST_ACK);
	assign o_rd_valid = rd_valid_reg && o_ack;
	assign o_rd_data = rd_data_reg;
	assign o_rd_par = rd_par_reg;
	assign o_sensor_active = (state_reg != srp_pkg::SRP_ST_OFF);
	assign o_protect_active = protect_reg;

	default clocking cb @(posedge i_clock); endclocking
	default disable iff (!i_rst_n);

	sequence s_read_answer;
		(state_reg == srp_pkg::SRP_ST_READ) ##1 (o_ack && o_rd_valid);
	endsequence

	// A legal write taken right after the dropped one may answer in the second cycle
	sequence s_silent_two;
		!o_ack ##1 (!o_ack || $past(take));
	endsequence

	a_read_two_cycles: assert property (take && i_tel_cmd == `SRP_CMD_READ |=> s_read_answer)
		else $error("read answer not two cycles after request");
	a_write_one_cycle: assert property (take && i_tel_cmd == `SRP_CMD_WRITE
		&& !(i_tel_adr == `SRP_ADR_SHUTDOWN && i_tel_data[11:0] == `SRP_SHUTDOWN_KEY) |=> o_ack && !o_rd_valid)
		else $error("write not acknowledged next cycle");
	a_parity_drop: assert property (i_tel_valid && state_reg == srp_pkg::SRP_ST_IDLE && !par_ok |=> s_silent_two)
		else $error("telegram with bad parity acknowledged");
	a_shutdown_key: assert property (take && i_tel_cmd == `SRP_CMD_WRITE && i_tel_adr == `SRP_ADR_SHUTDOWN
		&& i_tel_data[11:0] == `SRP_SHUTDOWN_KEY |=> !o_sensor_active && !o_ack)
		else $error("shutdown key did not deactivate");
	a_shutdown_holds: assert property (!o_sensor_active && !act_edge |=> !o_sensor_active)
		else $error("sensor woke without activate pulse");
	a_lock_at_powerup: assert property (state_reg != srp_pkg::SRP_ST_LOAD |=> protect_reg == $past(protect_reg))
		else $error("protection changed outside power-up");
	a_locked_no_change: assert property (protect_reg |-> !mem_wr_en && !mem_erase && !mem_program)
		else $error("stored settings changed while protected");
	a_lock_bit_frozen: assert property (protect_reg |=> lock_nv_reg == $past(lock_nv_reg))
		else $error("stored lock bit changed while protected");
	a_program_after_erase: assert property (mem_program |-> erased_reg ##1 !erased_reg)
		else $error("program without prior erase");
	a_store_all_ack: assert property ((mem_erase || mem_program) |=> o_ack)
		else $error("store completion not acknowledged");
	a_read_high_zero: assert property (o_rd_valid |-> o_rd_data[15:14] == 2'h0 && o_rd_par == ~^o_rd_data)
		else $error("read word upper bits or parity wrong");
endmodule // srp_register_programming
`default_nettype wire

/* File: src/srp_consts.svh */
// Named constants of the sensor register-programming block
`ifndef SRP_CONSTS_SVH
`define SRP_CONSTS_SVH

// Command codes
`define SRP_CMD_READ 3'h2
`define SRP_CMD_WRITE 3'h3
`define SRP_CMD_PROGRAM 3'h4
`define SRP_CMD_ERASE 3'h5

// Register addresses
`define SRP_ADR_CLAMP_LOW 4'h1
`define SRP_ADR_CLAMP_HIGH 4'h2
`define SRP_ADR_QUIESCENT 4'h3
`define SRP_ADR_GAIN 4'h4
`define SRP_ADR_CONFIG 4'h5
`define SRP_ADR_PROTECT 4'h6
`define SRP_ADR_SPARE13 4'h8
`define SRP_ADR_DAC 4'h9
`define SRP_ADR_TEMPCO 4'hb
`define SRP_ADR_SPARE0 4'hc
`define SRP_ADR_SHUTDOWN 4'hf

// Store slots of the three spare words behind one address
`define SRP_SLOT_SPARE13_0 4'hd
`define SRP_SLOT_SPARE13_1 4'he
`define SRP_SLOT_SPARE13_2 4'ha
`define SRP_SPARE13_LAST 2'h2

// Data field widths
`define SRP_W_CLAMP_LOW 4'h8
`define SRP_W_CLAMP_HIGH 4'h9
`define SRP_W_QUIESCENT 4'hb
`define SRP_W_GAIN 4'he
`define SRP_W_CONFIG 4'ha
`define SRP_W_PROTECT 4'h1
`define SRP_W_SPARE 4'hd
`define SRP_W_DAC 4'he
`define SRP_W_TEMPCO 4'ha
`define SRP_W_SHUTDOWN 4'hc
`define SRP_W_FIELD 4'he

// Shutdown key
`define SRP_SHUTDOWN_KEY 12'h80f

// Store time and clock rate
`define SRP_PROG_TIME_MS 100
`define SRP_CLK_KHZ 50000

`endif

/* File: src/srp_pkg.sv */
// Types of the sensor register-programming block
package srp_pkg;
	typedef enum logic [5:0] {
		SRP_ST_LOAD = 6'h01,
		SRP_ST_IDLE = 6'h02,
		SRP_ST_READ = 6'h04,
		SRP_ST_BUSY = 6'h08,
		SRP_ST_ACK = 6'h10,
		SRP_ST_OFF = 6'h20
	} srp_state_t;

	typedef logic [13:0] srp_word_t;
endpackage

/* File: src/srp_word_store.sv */
// Working copies and non-volatile copies of the sensor settings
`timescale 1ns/1ps
`default_nettype none
module srp_word_store (
	input wire logic i_clock,
	input wire logic i_rst_n,
	input wire logic i_wr_en,
	input wire logic [3:0] i_wr_idx,
	input wire srp_pkg::srp_word_t i_wr_data,
	input wire logic [3:0] i_rd_idx,
	input wire logic i_erase,
	input wire logic i_program,
	input wire logic i_reload,
	output srp_pkg::srp_word_t o_rd_data
);
	srp_pkg::srp_word_t ram_reg [16];
	srp_pkg::srp_word_t nv_reg [16];
	srp_pkg::srp_word_t rd_reg;
	srp_pkg::srp_word_t rd_next;

	genvar g;
	generate
		for (g = 0; g < 16; g++) begin : g_entry
			srp_pkg::srp_word_t ram_next;
			srp_pkg::srp_word_t nv_next;
			always_comb begin
				ram_next = ram_reg[g];
				nv_next = nv_reg[g];
				if (i_reload) begin
					ram_next = nv_reg[g];
				end else if (i_wr_en && i_wr_idx == 4'(g)) begin
					ram_next = i_wr_data;
				end
				// Every entry at once, never one address
				if (i_erase) begin
					nv_next = '0;
				end else if (i_program) begin
					nv_next = ram_reg[g];
				end
			end
			// Non-volatile copy survives reset on purpose
			always_ff @(posedge i_clock) begin
				ram_reg[g] <= ram_next;
				nv_reg[g] <= nv_next;
			end
		end
	endgenerate

	always_comb begin
		rd_next = ram_reg[i_rd_idx];
	end

	always_ff @(posedge i_clock) begin
		if (!i_rst_n) begin
			rd_reg <= '0;
		end else begin
			rd_reg <= rd_next;
		end
	end

	assign o_rd_data = rd_reg;
endmodule // srp_word_store
`default_nettype wire

/* File: verif/srp_programmer.sv */
// Programmer model that sends sensor telegrams and checks the answers
`timescale 1ns/1ps
`default_nettype none
module srp_programmer (
	input wire logic i_clock,
	input wire logic i_ack,
	input wire logic i_rd_valid,
	input wire logic [15:0] i_rd_data,
	input wire logic i_rd_par,
	output logic o_tel_valid,
	output logic [2:0] o_tel_cmd,
	output logic o_tel_cmd_par,
	output logic [3:0] o_tel_adr,
	output logic o_tel_adr_par,
	output logic [15:0] o_tel_data,
	output logic o_tel_data_par
);
	initial begin
		o_tel_valid = 1'b0;
		o_tel_cmd = 3'h0;
		o_tel_cmd_par = 1'b0;
		o_tel_adr = 4'h0;
		o_tel_adr_par = 1'b0;
		o_tel_data = 16'h0000;
		o_tel_data_par = 1'b0;
	end

	// One telegram; lat counts cycles from taking edge to answer, 0 if none
	task automatic xfer(input logic [2:0] cmd, input logic [3:0] adr, input logic [15:0] data,
		input logic bad, input int max_wait, output int lat, output logic [15:0] rd);
		lat = 0;
		rd = 16'h0000;
		@(posedge i_clock);
		o_tel_valid <= 1'b1;
		o_tel_cmd <= cmd;
		o_tel_cmd_par <= ~^cmd;
		o_tel_adr <= adr;
		o_tel_adr_par <= ^adr;
		o_tel_data <= data;
		o_tel_data_par <= (~^data) ^ bad;
		@(posedge i_clock);
		// Released fields flip so a stale copy can never look valid
		o_tel_valid <= 1'b0;
		o_tel_cmd <= ~cmd;
		o_tel_cmd_par <= cmd_par_flip(cmd);
		o_tel_adr <= ~adr;
		o_tel_adr_par <= ~^adr;
		o_tel_data <= ~data;
		o_tel_data_par <= ^data;
		for (int n = 1; n <= max_wait && lat == 0; n++) begin
			#1;
			if (i_ack === 1'b1 && (i_rd_valid !== 1'b1 || i_rd_par === ~^i_rd_data)) begin
				lat = n;
				rd = i_rd_data;
			end else begin
				@(posedge i_clock);
			end
		end
	endtask

	function automatic logic cmd_par_flip(input logic [2:0] c);
		return ^c;
	endfunction
endmodule // srp_programmer
`default_nettype wire

/* File: verif/srp_register_programming_tb.sv */
// Self-checking bench of the register-programming block
`timescale 1ns/1ps
`default_nettype none
`include "srp_consts.svh"
module srp_register_programming_tb;
	localparam int unsigned P_PROG = 8;
	logic i_clock, i_rst_n, i_activate_pin;
	logic [13:0] i_dac_value, dac;
	logic tel_valid, tel_cmd_par, tel_adr_par, tel_data_par;
	logic [2:0] tel_cmd;
	logic [3:0] tel_adr;
	logic [15:0] tel_data, rd_data, rd;
	logic ack, rd_valid, rd_par, sensor_active, protect_active;
	logic [15:0] saved [10];
	// Spare word 0 first, then the three shared-address words in pointer order
	logic [3:0] adrs [10] = '{`SRP_ADR_CLAMP_LOW, `SRP_ADR_CLAMP_HIGH, `SRP_ADR_QUIESCENT, `SRP_ADR_GAIN,
		`SRP_ADR_CONFIG, `SRP_ADR_TEMPCO, `SRP_ADR_SPARE0, `SRP_ADR_SPARE13, `SRP_ADR_SPARE13, `SRP_ADR_SPARE13};
	logic [3:0] wids [10] = '{`SRP_W_CLAMP_LOW, `SRP_W_CLAMP_HIGH, `SRP_W_QUIESCENT, `SRP_W_GAIN,
		`SRP_W_CONFIG, `SRP_W_TEMPCO, `SRP_W_SPARE, `SRP_W_SPARE, `SRP_W_SPARE, `SRP_W_SPARE};
	logic [31:0] seed;
	int lat, miscompares, total_checks;

	srp_register_programming #(.P_PROG_CYCLES(P_PROG)) i_dut (.i_clock(i_clock), .i_rst_n(i_rst_n),
		.i_tel_valid(tel_valid), .i_tel_cmd(tel_cmd), .i_tel_cmd_par(tel_cmd_par), .i_tel_adr(tel_adr),
		.i_tel_adr_par(tel_adr_par), .i_tel_data(tel_data), .i_tel_data_par(tel_data_par),
		.i_dac_value(i_dac_value), .i_activate_pin(i_activate_pin), .o_ack(ack), .o_rd_valid(rd_valid),
		.o_rd_data(rd_data), .o_rd_par(rd_par), .o_sensor_active(sensor_active),
		.o_protect_active(protect_active));

	srp_programmer i_prog (.i_clock(i_clock), .i_ack(ack), .i_rd_valid(rd_valid), .i_rd_data(rd_data),
		.i_rd_par(rd_par), .o_tel_valid(tel_valid), .o_tel_cmd(tel_cmd), .o_tel_cmd_par(tel_cmd_par),
		.o_tel_adr(tel_adr), .o_tel_adr_par(tel_adr_par), .o_tel_data(tel_data),
		.o_tel_data_par(tel_data_par));

	initial begin
		i_clock = 1'b0;
		forever #10 i_clock = ~i_clock;
	end

	function automatic logic [31:0] xs(input logic [31:0] x);
		x = x ^ (x << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction

	// Expected read word: value kept to its width, shown from bit 13 down
	function automatic logic [15:0] left(input logic [15:0] d, input logic [3:0] w);
		logic [15:0] m;
		m = (16'h0001 << w) - 16'h0001;
		return (d & m) << (4'he - w);
	endfunction

	function automatic logic [15:0] rev(input logic [13:0] x);
		logic [15:0] r;
		r = 16'h0000;
		for (int k = 0; k < 14; k++)
			r[13 - k] = x[k];
		return r;
	endfunction

	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		total_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic tx(input logic [2:0] c, input logic [3:0] a, input logic [15:0] d, input int m);
		i_prog.xfer(c, a, d, 1'b0, m, lat, rd);
	endtask

	task automatic power_up();
		@(posedge i_clock);
		i_rst_n <= 1'b0;
		repeat (3) @(posedge i_clock);
		i_rst_n <= 1'b1;
		repeat (2) @(posedge i_clock);
	endtask

	task automatic read_all();
		for (int i = 0; i < 10; i++) begin
			tx(`SRP_CMD_READ, adrs[i], 16'h0000, 4);
			check(16'(lat), 16'h0002);
			check(rd, left(saved[i], wids[i]));
		end
	endtask

	task automatic stop_test();
		$display("Checks %0d, mismatches %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	initial begin
		repeat (20000) @(posedge i_clock);
		miscompares++;
		stop_test();
	end

	initial begin
		seed = 32'h00000028;
		miscompares = 0;
		total_checks = 0;
		i_rst_n = 1'b0;
		i_activate_pin = 1'b0;
		i_dac_value = 14'h0000;
		repeat (2) @(posedge i_clock);
		#1;
		check({13'h0000, ack, rd_valid, rd_par}, 16'h0000);
		check(rd_data, 16'h0000);
		check({14'h0000, sensor_active, protect_active}, 16'h0002);
		@(posedge i_clock);
		i_rst_n <= 1'b1;
		repeat (2) @(posedge i_clock);
		$display("Test reset done");

		for (int i = 0; i < 10; i++) begin
			seed = xs(seed);
			saved[i] = seed[15:0];
			tx(`SRP_CMD_WRITE, adrs[i], saved[i], 4);
			check(16'(lat), 16'h0001);
		end
		tx(`SRP_CMD_ERASE, 4'h0, 16'h0000, 20);
		check(16'(lat), 16'(P_PROG + 1));
		tx(`SRP_CMD_PROGRAM, 4'h0, 16'h0000, 20);
		check(16'(lat), 16'(P_PROG + 1));
		read_all();
		seed = xs(seed);
		dac = seed[13:0];
		@(posedge i_clock);
		i_dac_value <= dac;
		tx(`SRP_CMD_READ, `SRP_ADR_DAC, 16'h0000, 4);
		check(rd, rev(dac));
		$display("Test store done");

		i_prog.xfer(`SRP_CMD_WRITE, adrs[0], ~saved[0], 1'b1, 4, lat, rd);
		check(16'(lat), 16'h0000);
		tx(3'h1, adrs[0], 16'h0000, 4);
		check(16'(lat), 16'h0000);
		read_all();
		$display("Test refusal done");

		// Power cycle: working copies must come back from the stored set
		power_up();
		read_all();
		check({15'h0000, protect_active}, 16'h0000);
		$display("Test restore done");

		tx(`SRP_CMD_WRITE, `SRP_ADR_PROTECT, 16'h0001, 4);
		check(16'(lat), 16'h0001);
		check({15'h0000, protect_active}, 16'h0000);
		power_up();
		tx(`SRP_CMD_READ, `SRP_ADR_PROTECT, 16'h0000, 4);
		check(rd, 16'h2000);
		check({15'h0000, protect_active}, 16'h0001);
		tx(`SRP_CMD_WRITE, adrs[0], ~saved[0], 4);
		check(16'(lat), 16'h0001);
		// Store while locked is answered but changes nothing
		tx(`SRP_CMD_ERASE, 4'h0, 16'h0000, 20);
		check(16'(lat), 16'(P_PROG + 1));
		tx(`SRP_CMD_PROGRAM, 4'h0, 16'h0000, 20);
		check(16'(lat), 16'(P_PROG + 1));
		read_all();
		$display("Test lock done");

		tx(`SRP_CMD_WRITE, `SRP_ADR_SHUTDOWN, 16'h0123, 4);
		check({15'h0000, sensor_active}, 16'h0001);
		seed = xs(seed);
		tx(`SRP_CMD_WRITE, `SRP_ADR_SHUTDOWN, {seed[15:12], `SRP_SHUTDOWN_KEY}, 4);
		check({15'(lat), sensor_active}, 16'h0000);
		tx(`SRP_CMD_READ, adrs[0], 16'h0000, 4);
		check(16'(lat), 16'h0000);
		@(posedge i_clock);
		i_activate_pin <= 1'b1;
		repeat (3) @(posedge i_clock);
		i_activate_pin <= 1'b0;
		repeat (8) @(posedge i_clock);
		#1;
		check({15'h0000, sensor_active}, 16'h0001);
		tx(`SRP_CMD_READ, adrs[0], 16'h0000, 4);
		check(rd, left(saved[0], wids[0]));
		$display("Test shutdown done");
		stop_test();
	end
endmodule // srp_register_programming_tb
`default_nettype wire
